// >>> capcmp_pkg.sv
// Package with register map, fields, bus carriers and mode decoding.
package capcmp_pkg;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] OFS_COUNTER_LO = 8'h00;
	localparam logic [7:0] OFS_COUNTER_HI = 8'h04;
	localparam logic [7:0] OFS_CAPTURE_LO = 8'h08;
	localparam logic [7:0] OFS_CAPTURE_HI = 8'h0C;
	localparam logic [7:0] OFS_CMPA_LO = 8'h10;
	localparam logic [7:0] OFS_CMPA_HI = 8'h14;
	localparam logic [7:0] OFS_CMPB_LO = 8'h18;
	localparam logic [7:0] OFS_CMPB_HI = 8'h1C;
	localparam logic [7:0] OFS_CONTROL = 8'h20;
	localparam logic [7:0] OFS_FLAGS = 8'h24;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h28;
	localparam logic [7:0] OFS_FORCE = 8'h2C;
	// ==========================================
	// Field positions and reset values
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_EDGE_BIT = 4;
	localparam int CTRL_FILTER_BIT = 5;
	localparam int CTRL_SOURCE_BIT = 6;
	localparam int CTRL_ACTION_LSB = 8;
	localparam int CTRL_WIDTH = 12;
	localparam int FLAG_CAPTURE_BIT = 0;
	localparam int FLAG_COMPARE_LSB = 1;
	localparam logic [11:0] CTRL_RESET = 12'h000;
	localparam logic [2:0] FLAGS_RESET = 3'h0;
	localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;
	// ==========================================
	// Timing counts in system clock cycles
	localparam int FILTER_SAMPLES = 4;
	localparam int SYNC_STAGES = 2;
	// ==========================================
	// Bus carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;
	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} apb_rsp_s;
	// ==========================================
	// Waveform mode decoding
	function automatic logic is_pwm(input logic [3:0] m);
		return !(m == 4'h0 || m == 4'h4 || m == 4'hC || m == 4'hD);
	endfunction
	function automatic logic capture_is_top(input logic [3:0] m);
		return (m == 4'h8 || m == 4'hA || m == 4'hC || m == 4'hE);
	endfunction
	function automatic logic update_at_top(input logic [3:0] m);
		return (m == 4'h1 || m == 4'h2 || m == 4'h3 || m == 4'hA || m == 4'hB);
	endfunction
endpackage

// >>> noise_filter.sv
// Four-sample majority-free noise filter with bypass.
`timescale 1ns/1ps
`default_nettype none
module noise_filter #(
	parameter int SAMPLES = 4
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic enable,
	input wire logic raw,
	output logic filtered
);
	import capcmp_pkg::*;
	typedef struct packed {
		logic [SAMPLES-1:0] hist;
		logic out;
	} filt_state_s;
	filt_state_s s;
	filt_state_s next_s;
	generate
		if (SAMPLES < 2) begin : g_check
			$error("SAMPLES must be at least two.");
		end
	endgenerate
	// ==========================================
	// With enable set, output changes only when every stored sample agrees; otherwise it follows raw.
	always_comb begin
		next_s = s;
		next_s.hist = {s.hist[SAMPLES-2:0], raw};
		if (!enable) begin
			next_s.out = raw;
		end else if (&s.hist) begin // RQ8 RQ9
			next_s.out = 1'b1;
		end else if (~|s.hist) begin // RQ8 RQ9
			next_s.out = 1'b0;
		end
	end
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end
	assign filtered = s.out;
endmodule
`default_nettype wire

// >>> compare_channel.sv
// One compare channel: double-buffered value, match and output state.
`timescale 1ns/1ps
`default_nettype none
module compare_channel (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [15:0] counter_value,
	input wire logic timer_tick,
	input wire logic block_match,
	input wire logic update_point,
	input wire logic pwm_mode,
	input wire logic cpu_write,
	input wire logic [15:0] cpu_data,
	input wire logic force_match_strobe,
	input wire logic [1:0] output_action_mode,
	output logic [15:0] compare_value,
	output logic [15:0] cpu_view,
	output logic match_event,
	output logic match_output_state
);
	import capcmp_pkg::*;
	typedef struct packed {
		logic [15:0] active;
		logic [15:0] buffer;
		logic ocs;
	} chan_state_s;
	chan_state_s s;
	chan_state_s next_s;
	logic hit;
	// ==========================================
	// Match, buffer transfer and output action.
	always_comb begin
		next_s = s;
		hit = timer_tick && counter_value == s.active && !block_match; // RQ12 RQ20 RQ21
		if (pwm_mode && timer_tick && update_point) begin
			next_s.active = s.buffer; // RQ15
		end
		if (cpu_write) begin
			if (pwm_mode) begin
				next_s.buffer = cpu_data; // RQ16 RQ18
			end else begin
				next_s.active = cpu_data; // RQ15 RQ16 RQ18
			end
		end
		if (hit || (force_match_strobe && !pwm_mode)) begin // RQ19
			unique case (output_action_mode) // RQ22
				2'h0: next_s.ocs = s.ocs; // RQ24
				2'h1: next_s.ocs = !s.ocs;
				2'h2: next_s.ocs = 1'b0;
				2'h3: next_s.ocs = 1'b1;
			endcase
		end
	end
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s <= '0; // RQ23
		end else if (ce) begin
			s <= next_s;
		end
	end
	assign compare_value = s.active;
	assign cpu_view = pwm_mode ? s.buffer : s.active; // RQ17
	assign match_event = hit;
	assign match_output_state = s.ocs;
endmodule
`default_nettype wire

// >>> timer16_capture_compare_units.sv
// Capture unit, two compare channels and their APB register file.
// Function
// RQ1 - A qualifying trigger edge copies the 16-bit counter into the capture register.
// RQ2 - Capture flag sets in the same cycle the capture register loads.
// RQ3 - Enabled capture flag requests interrupt; clears on service or written one.
// RQ4 - Capture low-byte read latches high byte; high read returns latch.
// RQ5 - Capture register writable only in capture-top modes; high byte first.
// RQ6 - Trigger is capture pin, or comparator output when its select bit is set.
// RQ7 - Changing trigger source may capture; software clears flag afterwards.
// RQ8 - Filter output changes only after four equal consecutive samples.
// RQ9 - Enabled filter adds four system-clock cycles latency, independent of prescaler.
// RQ10 - Filter and edge detector work except in capture-top modes.
// RQ11 - Every new capture overwrites the capture register.
// RQ12 - Compare equality sets the compare flag one timer clock later; the code sets it one system clock after the match.
// RQ13 - Enabled compare flag requests interrupt; clears on service or written one.
// RQ14 - Compare channel A value can serve as counter top.
// RQ15 - PWM modes double buffer compare values; normal and clear-on-match do not.
// RQ16 - CPU compare access targets buffer when buffered, else active value.
// RQ17 - Compare reads return both bytes directly without the latch.
// RQ18 - High byte loads latch; low write loads all 16 bits at once.
// RQ19 - Force strobe acts like a match in non-PWM modes, without flag.
// RQ20 - A CPU counter write blocks matches in the next timer cycle.
// RQ21 - Counter written equal to top misses the top match.
// RQ22 - Output state survives mode changes; action bits act at once.
// RQ23 - Reset clears each channel output state to zero.
// RQ24 - Action setting zero leaves output state unchanged on matches.
// RQ25 - Edge-select bit chooses rising or falling trigger transitions.
// RQ26 - Trigger inputs are synchronised before filtering and edge detection.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module timer16_capture_compare_units #(
	parameter int CHANNELS = 2,
	parameter int SAMPLES = 4
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ce,
	input wire capcmp_pkg::apb_req_s apb_req,
	output capcmp_pkg::apb_rsp_s apb_rsp,
	input wire logic capture_pin,
	input wire logic comparator_output,
	input wire logic [15:0] counter_value,
	input wire logic timer_tick,
	input wire logic counter_at_top,
	input wire logic counter_at_bottom,
	input wire logic [2:0] irq_serviced,
	output logic counter_load,
	output logic [15:0] counter_load_value,
	output logic [15:0] capture_value,
	output logic [15:0] compare_a_value,
	output logic [2:0] irq_request,
	output logic [1:0] match_event,
	output logic [1:0] match_output_state
);
	import capcmp_pkg::*;

	typedef struct packed {
		logic [11:0] ctrl;
		logic [2:0] flags;
		logic [2:0] irq_en;
		logic [15:0] capture;
		logic [7:0] temp;
		logic [7:0] snap_hi;
		logic [31:0] rdata;
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic prev_trig;
		logic block;
		logic load;
		logic [15:0] load_value;
	} top_state_s;

	top_state_s s;
	top_state_s next_s;

	generate
		if (CHANNELS != 2) begin : g_chk_ch
			$error("CHANNELS must be two.");
		end
		if (SAMPLES != FILTER_SAMPLES) begin : g_chk_samples
			$error("SAMPLES must equal the filter sample count.");
		end
	endgenerate

	// ==========================================
	// Control decoding
	logic [3:0] mode;
	logic pwm;
	logic cap_top;
	logic upd_point;
	logic trig_raw;
	logic trig_filt;
	logic cap_event;
	logic [15:0] ch_view [CHANNELS];
	logic [15:0] ch_value [CHANNELS];
	logic [CHANNELS-1:0] ch_write;
	logic [CHANNELS-1:0] ch_force;
	logic [CHANNELS-1:0] ch_match;

	always_comb begin
		mode = s.ctrl[CTRL_MODE_LSB +: 4];
		pwm = is_pwm(mode); // RQ15
		cap_top = capture_is_top(mode);
		upd_point = update_at_top(mode) ? counter_at_top : counter_at_bottom;
	end

	// ==========================================
	// Trigger source selection and filter
	always_comb begin
		if (s.ctrl[CTRL_SOURCE_BIT]) begin // RQ6 RQ7
			trig_raw = s.sync2[1];
		end else begin
			trig_raw = s.sync2[0];
		end
	end

	noise_filter #(
		.SAMPLES(SAMPLES)
	) u_filter (
		.core_clk(core_clk),
		.srst(srst),
		.ce(ce),
		.enable(s.ctrl[CTRL_FILTER_BIT]), // RQ9
		.raw(trig_raw),
		.filtered(trig_filt)
	);

	// ==========================================
	// Edge detection
	always_comb begin
		if (cap_top) begin
			cap_event = 1'b0; // RQ10
		end else if (s.ctrl[CTRL_EDGE_BIT]) begin
			cap_event = trig_filt && !s.prev_trig; // RQ25
		end else begin
			cap_event = !trig_filt && s.prev_trig; // RQ25
		end
	end

	// ==========================================
	// APB decoding
	logic setup;
	logic access;
	logic mapped;
	logic wr;
	logic rd;
	logic [7:0] wbyte;
	logic [15:0] wword;

	always_comb begin
		setup = apb_req.psel && !apb_req.penable;
		access = apb_req.psel && apb_req.penable && ce;
		mapped = apb_req.paddr[1:0] == 2'h0 && apb_req.paddr <= OFS_FORCE;
		wr = access && apb_req.pwrite && mapped;
		rd = access && !apb_req.pwrite && mapped;
		wbyte = apb_req.pwdata[7:0];
		wword = {s.temp, wbyte};
	end

	always_comb begin
		ch_write[0] = wr && apb_req.paddr == OFS_CMPA_LO; // RQ18
		ch_write[1] = wr && apb_req.paddr == OFS_CMPB_LO; // RQ18
		ch_force = '0;
		if (wr && apb_req.paddr == OFS_FORCE) begin
			ch_force = wbyte[1:0]; // RQ19
		end
	end

	// ==========================================
	// Compare channels
	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
			compare_channel u_chan (
				.core_clk(core_clk),
				.srst(srst),
				.ce(ce),
				.counter_value(counter_value),
				.timer_tick(timer_tick),
				.block_match(s.block), // RQ20 RQ21
				.update_point(upd_point),
				.pwm_mode(pwm),
				.cpu_write(ch_write[gi]),
				.cpu_data(wword),
				.force_match_strobe(ch_force[gi]),
				.output_action_mode(s.ctrl[CTRL_ACTION_LSB + 2 * gi +: 2]),
				.compare_value(ch_value[gi]),
				.cpu_view(ch_view[gi]),
				.match_event(ch_match[gi]),
				.match_output_state(match_output_state[gi])
			);
		end
	endgenerate

	// ==========================================
	// Read data selection at the setup cycle
	logic [7:0] rd_byte;
	logic [7:0] rd_snap;

	always_comb begin
		rd_byte = 8'h00;
		rd_snap = s.snap_hi;
		unique case (apb_req.paddr)
			OFS_COUNTER_LO: begin
				rd_byte = counter_value[7:0];
				rd_snap = counter_value[15:8];
			end
			OFS_COUNTER_HI: rd_byte = s.temp;
			OFS_CAPTURE_LO: begin
				rd_byte = s.capture[7:0];
				rd_snap = s.capture[15:8]; // RQ4
			end
			OFS_CAPTURE_HI: rd_byte = s.temp; // RQ4
			OFS_CMPA_LO: rd_byte = ch_view[0][7:0]; // RQ17
			OFS_CMPA_HI: rd_byte = ch_view[0][15:8]; // RQ17
			OFS_CMPB_LO: rd_byte = ch_view[1][7:0]; // RQ17
			OFS_CMPB_HI: rd_byte = ch_view[1][15:8]; // RQ17
			OFS_FLAGS: rd_byte = {5'h00, s.flags};
			OFS_IRQ_ENABLE: rd_byte = {5'h00, s.irq_en};
			default: rd_byte = 8'h00;
		endcase
	end

	// ==========================================
	// State update
	logic [2:0] set_f;
	logic [2:0] clr_f;

	always_comb begin
		next_s = s;
		next_s.sync1 = {comparator_output, capture_pin}; // RQ26
		next_s.sync2 = s.sync1; // RQ26
		next_s.prev_trig = trig_filt;
		next_s.load = 1'b0;
		set_f = '0;
		clr_f = irq_serviced & irq_request; // RQ3 RQ13
		if (setup) begin
			next_s.snap_hi = rd_snap;
			if (apb_req.paddr == OFS_CONTROL) begin
				next_s.rdata = {20'h00000, s.ctrl};
			end else begin
				next_s.rdata = {24'h000000, rd_byte};
			end
		end
		if (timer_tick) begin
			next_s.block = 1'b0; // RQ20
		end
		if (cap_event) begin
			next_s.capture = counter_value; // RQ1 RQ11
			set_f[FLAG_CAPTURE_BIT] = 1'b1; // RQ2
		end
		set_f[FLAG_COMPARE_LSB +: 2] = ch_match; // RQ12
		if (rd && (apb_req.paddr == OFS_COUNTER_LO || apb_req.paddr == OFS_CAPTURE_LO)) begin
			next_s.temp = s.snap_hi; // RQ4
		end
		if (wr) begin
			unique case (apb_req.paddr)
				OFS_COUNTER_HI, OFS_CAPTURE_HI, OFS_CMPA_HI, OFS_CMPB_HI: begin
					next_s.temp = wbyte; // RQ18
				end
				OFS_COUNTER_LO: begin
					next_s.load = 1'b1;
					next_s.load_value = wword;
					next_s.block = 1'b1; // RQ20 RQ21
				end
				OFS_CAPTURE_LO: begin
					if (cap_top) begin
						next_s.capture = wword; // RQ5
					end
				end
				OFS_CONTROL: next_s.ctrl = apb_req.pwdata[CTRL_WIDTH-1:0]; // RQ22
				OFS_FLAGS: clr_f = clr_f | apb_req.pwdata[2:0]; // RQ3 RQ13
				OFS_IRQ_ENABLE: next_s.irq_en = apb_req.pwdata[2:0];
				default: begin
				end
			endcase
		end
		next_s.flags = (s.flags & ~clr_f) | set_f;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			s <= '0;
			s.ctrl <= CTRL_RESET;
			s.flags <= FLAGS_RESET;
			s.irq_en <= IRQ_ENABLE_RESET;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// ==========================================
	// Outputs
	always_comb begin
		apb_rsp.pready = access;
		apb_rsp.prdata = s.rdata;
		apb_rsp.pslverr = access && !mapped;
		irq_request = s.flags & s.irq_en; // RQ3 RQ13
		counter_load = s.load;
		counter_load_value = s.load_value;
		capture_value = s.capture;
		compare_a_value = ch_value[0]; // RQ14
		match_event = ch_match;
	end
endmodule
`default_nettype wire

// >>> counter_model.sv
// Partner model of the external counter with load, run control and wrap at top.
`timescale 1ns/1ps
`default_nettype none
module counter_model #(
	parameter logic [15:0] TOP = 16'h003F
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic run,
	input wire logic counter_load,
	input wire logic [15:0] counter_load_value,
	output logic [15:0] counter_value,
	output logic timer_tick,
	output logic counter_at_top,
	output logic counter_at_bottom
);
	logic [1:0] div;
	assign counter_at_top = counter_value == TOP;
	assign counter_at_bottom = counter_value == 16'h0000;
	assign timer_tick = run && div == 2'h3;
	always @(posedge core_clk) begin
		div <= srst ? 2'h0 : div + 2'h1;
		if (srst) begin
			counter_value <= 16'h0000;
		end else if (counter_load) begin
			counter_value <= counter_load_value;
		end else if (timer_tick) begin
			counter_value <= counter_at_top ? 16'h0000 : counter_value + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// >>> capcmp_asserts.sv
// Concurrent checks on the capture and compare block ports.
`timescale 1ns/1ps
`default_nettype none
module capcmp_checker
	import capcmp_pkg::*;
#(
	parameter int SAMPLES = 4
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ce,
	input wire capcmp_pkg::apb_req_s apb_req,
	input wire logic [15:0] counter_value,
	input wire logic timer_tick,
	input wire logic [2:0] irq_serviced,
	input wire logic counter_load,
	input wire logic [15:0] counter_load_value,
	input wire logic [15:0] capture_value,
	input wire logic [15:0] compare_a_value,
	input wire logic [2:0] irq_request,
	input wire logic [1:0] match_event,
	input wire logic [1:0] match_output_state
);
	logic wr_acc;
	logic blk;
	assign wr_acc = apb_req.psel && apb_req.penable && ce && apb_req.pwrite;
	always_ff @(posedge core_clk) begin
		if (srst || timer_tick) begin
			blk <= 1'b0;
		end else if (counter_load) begin
			blk <= 1'b1;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence cnt_lo_write;
		wr_acc && apb_req.paddr == OFS_COUNTER_LO;
	endsequence
	chk_capture_copy:
		assert property ($changed(capture_value) && !$past(wr_acc && apb_req.paddr == OFS_CAPTURE_LO)
			|-> capture_value == $past(counter_value)) else $error("Capture not from counter.");
	chk_capture_flag:
		assert property ($rose(irq_request[0]) && !$past(wr_acc && apb_req.paddr == OFS_IRQ_ENABLE)
			|-> capture_value == $past(counter_value)) else $error("Capture flag without load.");
	chk_cap_service:
		assert property (irq_request[0] && irq_serviced[0] |=> !irq_request[0])
		else $error("Capture flag not cleared by service.");
	chk_match_equal:
		assert property (match_event[0] |-> timer_tick && counter_value == compare_a_value)
		else $error("Match without equality.");
	chk_match_flag:
		assert property ($rose(irq_request[1]) && !$past(wr_acc && apb_req.paddr == OFS_IRQ_ENABLE)
			|-> $past(match_event[0])) else $error("Compare flag without match.");
	chk_cmp_service:
		assert property (irq_request[1] && irq_serviced[1] && !match_event[0] |=> !irq_request[1])
		else $error("Compare flag not cleared by service.");
	chk_reset_clear:
		assert property (disable iff (1'b0) srst && ce |=> match_output_state == 2'b00
			&& irq_request == 3'h0 && capture_value == 16'h0000) else $error("Reset state wrong.");
	chk_counter_load:
		assert property (cnt_lo_write |=> counter_load
			&& counter_load_value[7:0] == $past(apb_req.pwdata[7:0])) else $error("Counter load wrong.");
	chk_write_block:
		assert property (counter_load || blk |-> match_event == 2'b00)
		else $error("Match not blocked after counter write.");
endmodule
bind timer16_capture_compare_units capcmp_checker #(.SAMPLES(SAMPLES)) i_chk (
	.core_clk(core_clk), .srst(srst), .ce(ce), .apb_req(apb_req),
	.counter_value(counter_value), .timer_tick(timer_tick), .irq_serviced(irq_serviced),
	.counter_load(counter_load), .counter_load_value(counter_load_value),
	.capture_value(capture_value), .compare_a_value(compare_a_value),
	.irq_request(irq_request), .match_event(match_event), .match_output_state(match_output_state)
);
`default_nettype wire

// >>> tb_timer16_capture_compare_units.sv
// Self-checking bench for the capture and compare block.
`timescale 1ns/1ps
`default_nettype none
module tb_timer16_capture_compare_units;
	import capcmp_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic run = 1'b0;
	logic capture_pin = 1'b0;
	logic comparator_output = 1'b0;
	logic [2:0] irq_serviced = 3'h0;
	apb_req_s req = '0;
	apb_rsp_s rsp;
	logic [15:0] counter_value, counter_load_value, capture_value, compare_a_value;
	logic timer_tick, counter_at_top, counter_at_bottom, counter_load;
	logic [2:0] irq_request;
	logic [1:0] match_event, match_output_state;
	logic [32:0] q[$];
	logic [7:0] ra [6] = '{OFS_CONTROL, OFS_FLAGS, OFS_IRQ_ENABLE, OFS_CAPTURE_LO, OFS_FORCE, 8'h30};
	int failures = 0;
	int cmp_count = 0;
	int seed = 25708;
	int n0, n;
	logic [15:0] cnt, c2, v;
	always #5 core_clk = ~core_clk;
	timer16_capture_compare_units #(.CHANNELS(2), .SAMPLES(4)) i_dut (
		.core_clk(core_clk), .srst(srst), .ce(ce), .apb_req(req), .apb_rsp(rsp),
		.capture_pin(capture_pin), .comparator_output(comparator_output),
		.counter_value(counter_value), .timer_tick(timer_tick), .counter_at_top(counter_at_top),
		.counter_at_bottom(counter_at_bottom), .irq_serviced(irq_serviced),
		.counter_load(counter_load), .counter_load_value(counter_load_value),
		.capture_value(capture_value), .compare_a_value(compare_a_value),
		.irq_request(irq_request), .match_event(match_event), .match_output_state(match_output_state)
	);
	counter_model i_cnt (
		.core_clk(core_clk), .srst(srst), .run(run), .counter_load(counter_load),
		.counter_load_value(counter_load_value), .counter_value(counter_value),
		.timer_tick(timer_tick), .counter_at_top(counter_at_top), .counter_at_bottom(counter_at_bottom)
	);
	// ==========================================
	// Reporting and bus tasks.
	task automatic tally_and_finish;
		$display("failures %0d comparisons %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			failures++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [15:0] d, input logic [32:0] e);
		if (!w) begin
			q.push_back(e);
		end
		@(posedge core_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {16'h0000, d}};
		@(posedge core_clk);
		req.penable <= 1'b1;
		do @(posedge core_clk); while (rsp.pready !== 1'b1);
		req <= '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(a, 1'b1, d, 33'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] m);
		apb(a, 1'b0, 16'h0000, {1'b0, m, d});
	endtask
	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		wr(a + 8'h04, {8'h00, d[15:8]});
		wr(a, {8'h00, d[7:0]});
	endtask
	task automatic wait_irq(input int b, output int k);
		k = 0;
		while (irq_request[b] !== 1'b1 && k < 300) begin
			@(posedge core_clk);
			k++;
		end
	endtask
	task automatic pin(input logic p);
		@(posedge core_clk);
		capture_pin <= p;
	endtask
	task automatic svc(input logic [2:0] s);
		@(posedge core_clk);
		irq_serviced <= s;
		@(posedge core_clk);
		irq_serviced <= 3'h0;
		@(negedge core_clk);
	endtask
	// ==========================================
	// Read monitor compares each read against the oldest note.
	always @(posedge core_clk) begin
		logic [32:0] e;
		if (req.psel && req.penable && rsp.pready && !req.pwrite) begin
			e = q.pop_front();
			check(rsp.pslverr === e[32] && (rsp.prdata[15:0] & e[31:16]) === e[15:0], "read data");
		end
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		tally_and_finish();
	end
	// ==========================================
	// Main sequence.
	initial begin
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		foreach (ra[i]) begin
			apb(ra[i], 1'b0, 16'h0000, {i == 5, 16'h0FFF, 16'h0000});
		end
		check(match_output_state === 2'b00, "reset state");
		wr(OFS_IRQ_ENABLE, 16'h0007);
		wr(OFS_CONTROL, 16'h0010);
		cnt = 16'($random(seed));
		wr16(OFS_COUNTER_LO, cnt);
		@(negedge core_clk);
		check(counter_load_value === cnt, "counter load");
		pin(1'b1);
		wait_irq(0, n0);
		check(capture_value === cnt, "capture");
		c2 = cnt ^ 16'hA5A5;
		wr16(OFS_COUNTER_LO, c2);
		svc(3'h1);
		check(irq_request[0] === 1'b0, "capture service");
		rd(OFS_CAPTURE_LO, {8'h00, cnt[7:0]}, 16'h00FF);
		pin(1'b0);
		repeat (12) @(posedge core_clk);
		check(irq_request[0] === 1'b0, "falling edge");
		pin(1'b1);
		wait_irq(0, n);
		check(capture_value === c2, "overwrite");
		rd(OFS_CAPTURE_HI, {8'h00, cnt[15:8]}, 16'h00FF);
		wr(OFS_CONTROL, 16'h0030);
		repeat (8) @(posedge core_clk);
		svc(3'h1);
		pin(1'b0);
		repeat (2) @(posedge core_clk);
		pin(1'b1);
		repeat (12) @(posedge core_clk);
		check(irq_request[0] === 1'b0, "glitch");
		pin(1'b0);
		repeat (12) @(posedge core_clk);
		pin(1'b1);
		wait_irq(0, n);
		check(n === n0 + FILTER_SAMPLES, "filter delay");
		wr(OFS_CONTROL, 16'h0050);
		svc(3'h1);
		pin(1'b0);
		pin(1'b1);
		repeat (12) @(posedge core_clk);
		check(irq_request[0] === 1'b0, "pin ignored");
		@(posedge core_clk);
		comparator_output <= 1'b1;
		wait_irq(0, n);
		check(irq_request[0] === 1'b1, "comparator capture");
		wr(OFS_CONTROL, 16'h001C);
		v = 16'($random(seed));
		wr16(OFS_CAPTURE_LO, v);
		svc(3'h1);
		pin(1'b0);
		pin(1'b1);
		repeat (12) @(posedge core_clk);
		check(capture_value === v && irq_request[0] === 1'b0, "top mode");
		wr(OFS_CONTROL, 16'h0100);
		wr16(OFS_CMPA_LO, 16'h0010);
		@(negedge core_clk);
		check(compare_a_value === 16'h0010, "direct compare");
		wr16(OFS_CMPB_LO, v);
		wr(OFS_COUNTER_HI, {8'h00, ~v[15:8]});
		rd(OFS_CMPB_HI, {8'h00, v[15:8]}, 16'h00FF);
		wr16(OFS_COUNTER_LO, 16'h0000);
		wr(OFS_FLAGS, 16'h0007);
		@(posedge core_clk);
		run <= 1'b1;
		wait_irq(1, n);
		@(negedge core_clk);
		check(match_output_state === 2'b01, "toggle");
		svc(3'h2);
		check(irq_request[1] === 1'b0, "compare service");
		wr(OFS_CONTROL, 16'h0104);
		@(negedge core_clk);
		check(match_output_state[0] === 1'b1, "mode change");
		wr16(OFS_CMPA_LO, 16'hFFFF);
		wr(OFS_FLAGS, 16'h0007);
		wr(OFS_FORCE, 16'h0001);
		@(negedge core_clk);
		check(match_output_state[0] === 1'b0, "force");
		rd(OFS_FLAGS, 16'h0000, 16'h0002);
		wr(OFS_CONTROL, 16'h0304);
		wr(OFS_FORCE, 16'h0001);
		wr(OFS_CONTROL, 16'h0204);
		@(negedge core_clk);
		check(match_output_state === 2'b01, "force set");
		wr(OFS_FORCE, 16'h0001);
		@(negedge core_clk);
		check(match_output_state === 2'b00, "force clear");
		wr(OFS_CONTROL, 16'h0105);
		wr16(OFS_CMPA_LO, 16'h0030);
		@(negedge core_clk);
		check(compare_a_value === 16'hFFFF, "buffered");
		n = 0;
		while (compare_a_value !== 16'h0030 && n < 400) begin
			@(posedge core_clk);
			n++;
		end
		check(counter_value === 16'h0001, "bottom update");
		@(posedge core_clk);
		run <= 1'b0;
		wr16(OFS_COUNTER_LO, 16'h0030);
		wr(OFS_FLAGS, 16'h0007);
		@(posedge core_clk);
		run <= 1'b1;
		repeat (12) @(posedge core_clk);
		rd(OFS_FLAGS, 16'h0000, 16'h0002);
		@(posedge core_clk);
		ce <= 1'b0;
		pin(1'b0);
		repeat (12) @(posedge core_clk);
		check(irq_request[0] === 1'b0 && capture_value === v, "clock enable hold");
		@(posedge core_clk);
		ce <= 1'b1;
		wait_irq(0, n);
		check(n === n0 && irq_request[0] === 1'b1, "clock enable resume");
		tally_and_finish();
	end
endmodule
`default_nettype wire
